// [hw/bsls_pkg.sv]
// Shared types and constants for the branch, skip, load and store unit.
// Assumes a single 25 MHz clock and an AHB-Lite register port.
package bsls_pkg;

   // ==========================================================
   // Register map (byte addresses, one word each)
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PC = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_GPR = 8'h80;

   // ==========================================================
   // Register fields and reset values
   localparam int CTRL_NEXT2_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TAKEN_BIT = 1;
   localparam int STAT_REFUSED_BIT = 2;
   localparam int STAT_CYC_LO = 8;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] GPR_RST = 8'h00;
   localparam logic [31:0] INSTR_RST = 32'h0000_0000;

   // ==========================================================
   // Status flag positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;

   // ==========================================================
   // Operand positions inside the 17-bit immediate field
   localparam int IMM_PTR_LO = 15;
   localparam int IMM_MODE_LO = 13;
   localparam int IMM_IOA_LO = 3;
   localparam int IMM_S_LO = 7;
   localparam logic [4:0] PTR_X_LO = 5'h1A;
   localparam logic [4:0] PTR_Y_LO = 5'h1C;
   localparam logic [4:0] PTR_Z_LO = 5'h1E;
   localparam logic [1:0] MODE_PLAIN = 2'h0;
   localparam logic [1:0] MODE_POSTINC = 2'h1;
   localparam logic [1:0] MODE_PREDEC = 2'h2;

   // ==========================================================
   // Nominal cycle counts
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;

   // ==========================================================
   // Operations, instruction word, state and memory request
   typedef enum logic [4:0] {
      OP_POINTER_CALL, OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL,
      OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_MINUS,
      OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR,
      OP_BRANCH_TFLAG_SET, OP_BRANCH_TFLAG_CLEAR, OP_BRANCH_OVERFLOW_SET,
      OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED,
      OP_BRANCH_IRQ_DISABLED, OP_LOAD_DIRECT, OP_LOAD_INDIRECT,
      OP_LOAD_DISPLACED, OP_STORE_DIRECT, OP_STORE_INDIRECT,
      OP_STORE_DISPLACED
   } bsls_op_t;

   typedef struct packed {
      bsls_op_t op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [16:0] imm;
   } bsls_instr_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC} bsls_state_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bsls_dm_req_t;

endpackage

// [hw/bsls_exec.sv]
// Execution unit for calls through a pointer, skips, flag branches and
// data-space loads and stores, with its state reachable over AHB-Lite.
// Assumes a zero-wait AHB-Lite master and a data-space memory that
// answers each request with a ready pulse, on the same clock or later.
//
// Functional notes
// - Pointer call loads PC low 16 bits from Z, clears upper; 2/3 cycles
// - Equal registers skip the next instruction; 1/2/3 cycles
// - Register bit skips act on bit clear or set; flags untouched
// - I/O bit skips test one I/O bit clear or set; 1/2/3 cycles
// - Generic flag branches jump to PC plus k plus one; 1/2 cycles
// - Equal branches test Z; carry, lower, same-higher branches test C
// - Minus/plus test N; signed ge/lt test N xor V
// - Half-carry and T flag branches, set and clear forms, 1/2 cycles
// - Overflow and interrupt-enable branches, both forms, 1/2 cycles
// - Direct load reads byte at 16-bit address; 3 cycles, no flags
// - Indirect load, plain or post-increment pointer; 2 cycles
// - Pre-decrement load lowers pointer, then reads there; 2 cycles
// - Displaced load reads Y or Z plus q, pointer kept; 2 cycles
// - Direct store writes register to 16-bit address; 2 cycles
// - Indirect store, plain or post-increment pointer; 1 cycle
// - Pre-decrement store lowers pointer, then writes; 1 cycle
// - Displaced store writes to Y or Z plus q, pointer kept; 1 cycle
module bsls_exec #(
   parameter int PC_W = 22
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output bsls_pkg::bsls_dm_req_t DM_REQ,
   input wire logic [7:0] DM_RDATA,
   input wire logic DM_READY,
   output logic [4:0] IO_ADDR,
   input wire logic [7:0] IO_RDATA
);

   // ==========================================================
   // State
   bsls_pkg::bsls_state_t state_q;
   bsls_pkg::bsls_instr_t ir_q;
   logic [7:0] rf_q [32];
   logic [7:0] flags_q;
   logic [PC_W-1:0] pc_q;
   logic next2_q;
   logic refused_q;
   logic taken_q;
   logic [2:0] last_cyc_q;
   logic [2:0] cyc_q;
   logic mem_done_q;
   logic [7:0] ld_q;
   logic wr_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;

   // Decode results
   logic exec;
   logic done;
   logic start;
   logic cond;
   logic is_mem;
   logic mem_we;
   logic [15:0] mem_addr;
   logic [15:0] ptr_val;
   logic [15:0] ptr_new;
   logic ptr_wr;
   logic [4:0] ptr_lo;
   logic rd_wr;
   logic [2:0] need;
   logic [PC_W-1:0] pc_d;
   logic [7:0] ld_data;
   logic ap_valid;
   logic [31:0] rd_mux;
   logic [2:0] bsel;
   logic [2:0] ssel;
   logic [1:0] mode;
   logic [5:0] disp;

   // ==========================================================
   // Bus slave: address phase capture and zero-wait answer
   assign ap_valid = HSEL && HREADY && HTRANS[1];
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_q;

   // Write address held over into the data phase
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wr_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_q <= ap_valid && HWRITE && (HADDR[31:8] == 24'h00_0000);
         wr_addr_q <= HADDR[7:0];
      end
   end

   // Read mux over the register map
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (HADDR[31:8] == 24'h00_0000) begin
         if (HADDR[7] && (HADDR[1:0] == 2'h0)) begin
            rd_mux[7:0] = rf_q[HADDR[6:2]];
         end else begin
            case (HADDR[7:0])
               bsls_pkg::OFS_INSTR: rd_mux = ir_q;
               bsls_pkg::OFS_CTRL: rd_mux[bsls_pkg::CTRL_NEXT2_BIT] = next2_q;
               bsls_pkg::OFS_STATUS: begin
                  rd_mux[bsls_pkg::STAT_BUSY_BIT] = exec;
                  rd_mux[bsls_pkg::STAT_TAKEN_BIT] = taken_q;
                  rd_mux[bsls_pkg::STAT_REFUSED_BIT] = refused_q;
                  rd_mux[bsls_pkg::STAT_CYC_LO +: 3] = last_cyc_q;
               end
               bsls_pkg::OFS_PC: rd_mux[PC_W-1:0] = pc_q;
               bsls_pkg::OFS_FLAGS: rd_mux[7:0] = flags_q;
               default: rd_mux = 32'h0000_0000;
            endcase
         end
      end
   end

   // Read data registered for the data phase
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ap_valid && !HWRITE) begin
         hrdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // Control and status registers
   assign exec = (state_q == bsls_pkg::ST_EXEC);
   assign start = wr_q && (wr_addr_q == bsls_pkg::OFS_INSTR) && !exec;

   // Next-instruction length, software only
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         next2_q <= 1'b0;
      end else if (wr_q && (wr_addr_q == bsls_pkg::OFS_CTRL)) begin
         next2_q <= HWDATA[bsls_pkg::CTRL_NEXT2_BIT];
      end
   end

   // Flags: software writes; these operations never alter them
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         flags_q <= bsls_pkg::FLAGS_RST;
      end else if (wr_q && (wr_addr_q == bsls_pkg::OFS_FLAGS)) begin
         flags_q <= HWDATA[7:0];
      end
   end

   // Sticky refusal of a start while busy; a new refusal beats the clear
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         refused_q <= 1'b0;
      end else if (wr_q && (wr_addr_q == bsls_pkg::OFS_INSTR) && exec) begin
         refused_q <= 1'b1;
      end else if (wr_q && (wr_addr_q == bsls_pkg::OFS_STATUS) &&
                   HWDATA[bsls_pkg::STAT_REFUSED_BIT]) begin
         refused_q <= 1'b0;
      end
   end

   // Instruction register, loaded only when idle
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ir_q <= bsls_pkg::INSTR_RST;
      end else if (start) begin
         ir_q <= HWDATA;
      end
   end

   // ==========================================================
   // Operand fields and pointer selection
   assign bsel = ir_q.imm[2:0];
   assign ssel = ir_q.imm[bsls_pkg::IMM_S_LO +: 3];
   assign mode = ir_q.imm[bsls_pkg::IMM_MODE_LO +: 2];
   assign disp = ir_q.imm[5:0];
   assign IO_ADDR = ir_q.imm[bsls_pkg::IMM_IOA_LO +: 5];

   // Pointer pair: X, Y or Z; displaced forms only Y or Z
   always_comb begin
      case (ir_q.imm[bsls_pkg::IMM_PTR_LO +: 2])
         2'h0: ptr_lo = (ir_q.op == bsls_pkg::OP_LOAD_INDIRECT ||
                         ir_q.op == bsls_pkg::OP_STORE_INDIRECT) ?
                        bsls_pkg::PTR_X_LO : bsls_pkg::PTR_Y_LO;
         2'h1: ptr_lo = bsls_pkg::PTR_Y_LO;
         default: ptr_lo = bsls_pkg::PTR_Z_LO;
      endcase
      if (ir_q.op == bsls_pkg::OP_POINTER_CALL) begin
         ptr_lo = bsls_pkg::PTR_Z_LO;
      end
   end
   assign ptr_val = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};

   // ==========================================================
   // Condition, timing, address and next PC
   always_comb begin
      cond = 1'b0;
      is_mem = 1'b0;
      mem_we = 1'b0;
      mem_addr = 16'h0000;
      ptr_new = ptr_val;
      ptr_wr = 1'b0;
      rd_wr = 1'b0;
      need = bsls_pkg::CYC_ONE;
      pc_d = pc_q + PC_W'(1);
      case (ir_q.op)
         bsls_pkg::OP_POINTER_CALL: begin
            pc_d = PC_W'(ptr_val);
            need = (PC_W > 16) ? bsls_pkg::CYC_THREE : bsls_pkg::CYC_TWO;
         end
         bsls_pkg::OP_COMPARE_SKIP_EQUAL:
            cond = (rf_q[ir_q.rd] == rf_q[ir_q.rr]);
         bsls_pkg::OP_SKIP_REG_BIT_CLEAR: cond = !rf_q[ir_q.rr][bsel];
         bsls_pkg::OP_SKIP_REG_BIT_SET: cond = rf_q[ir_q.rr][bsel];
         bsls_pkg::OP_SKIP_IO_BIT_CLEAR: cond = !IO_RDATA[bsel];
         bsls_pkg::OP_SKIP_IO_BIT_SET: cond = IO_RDATA[bsel];
         bsls_pkg::OP_BRANCH_FLAG_SET: cond = flags_q[ssel];
         bsls_pkg::OP_BRANCH_FLAG_CLEAR: cond = !flags_q[ssel];
         bsls_pkg::OP_BRANCH_EQUAL: cond = flags_q[bsls_pkg::FLG_Z];
         bsls_pkg::OP_BRANCH_NOT_EQUAL: cond = !flags_q[bsls_pkg::FLG_Z];
         bsls_pkg::OP_BRANCH_CARRY_SET,
         bsls_pkg::OP_BRANCH_LOWER: cond = flags_q[bsls_pkg::FLG_C];
         bsls_pkg::OP_BRANCH_CARRY_CLEAR,
         bsls_pkg::OP_BRANCH_SAME_HIGHER:
            cond = !flags_q[bsls_pkg::FLG_C];
         bsls_pkg::OP_BRANCH_MINUS: cond = flags_q[bsls_pkg::FLG_N];
         bsls_pkg::OP_BRANCH_PLUS: cond = !flags_q[bsls_pkg::FLG_N];
         bsls_pkg::OP_BRANCH_SIGNED_GE:
            cond = !(flags_q[bsls_pkg::FLG_N] ^ flags_q[bsls_pkg::FLG_V]);
         bsls_pkg::OP_BRANCH_SIGNED_LT:
            cond = flags_q[bsls_pkg::FLG_N] ^ flags_q[bsls_pkg::FLG_V];
         bsls_pkg::OP_BRANCH_HALFCARRY_SET: cond = flags_q[bsls_pkg::FLG_H];
         bsls_pkg::OP_BRANCH_HALFCARRY_CLEAR:
            cond = !flags_q[bsls_pkg::FLG_H];
         bsls_pkg::OP_BRANCH_TFLAG_SET: cond = flags_q[bsls_pkg::FLG_T];
         bsls_pkg::OP_BRANCH_TFLAG_CLEAR: cond = !flags_q[bsls_pkg::FLG_T];
         bsls_pkg::OP_BRANCH_OVERFLOW_SET: cond = flags_q[bsls_pkg::FLG_V];
         bsls_pkg::OP_BRANCH_OVERFLOW_CLEAR:
            cond = !flags_q[bsls_pkg::FLG_V];
         bsls_pkg::OP_BRANCH_IRQ_ENABLED: cond = flags_q[bsls_pkg::FLG_I];
         bsls_pkg::OP_BRANCH_IRQ_DISABLED: cond = !flags_q[bsls_pkg::FLG_I];
         bsls_pkg::OP_LOAD_DIRECT: begin
            is_mem = 1'b1;
            rd_wr = 1'b1;
            mem_addr = ir_q.imm[15:0];
            need = bsls_pkg::CYC_THREE;
            pc_d = pc_q + PC_W'(2);
         end
         bsls_pkg::OP_STORE_DIRECT: begin
            is_mem = 1'b1;
            mem_we = 1'b1;
            mem_addr = ir_q.imm[15:0];
            need = bsls_pkg::CYC_TWO;
            pc_d = pc_q + PC_W'(2);
         end
         bsls_pkg::OP_LOAD_INDIRECT,
         bsls_pkg::OP_STORE_INDIRECT: begin
            is_mem = 1'b1;
            mem_we = (ir_q.op == bsls_pkg::OP_STORE_INDIRECT);
            rd_wr = !mem_we;
            need = mem_we ? bsls_pkg::CYC_ONE : bsls_pkg::CYC_TWO;
            mem_addr = ptr_val;
            if (mode == bsls_pkg::MODE_POSTINC) begin
               ptr_new = ptr_val + 16'h0001;
               ptr_wr = 1'b1;
            end else if (mode == bsls_pkg::MODE_PREDEC) begin
               ptr_new = ptr_val - 16'h0001;
               mem_addr = ptr_new;
               ptr_wr = 1'b1;
            end
         end
         bsls_pkg::OP_LOAD_DISPLACED,
         bsls_pkg::OP_STORE_DISPLACED: begin
            is_mem = 1'b1;
            mem_we = (ir_q.op == bsls_pkg::OP_STORE_DISPLACED);
            rd_wr = !mem_we;
            need = mem_we ? bsls_pkg::CYC_ONE : bsls_pkg::CYC_TWO;
            mem_addr = ptr_val + {10'h000, disp};
         end
         default: cond = 1'b0;
      endcase
      // Skips jump over one or two words, branches go relative
      if (ir_q.op >= bsls_pkg::OP_COMPARE_SKIP_EQUAL &&
          ir_q.op <= bsls_pkg::OP_SKIP_IO_BIT_SET && cond) begin
         pc_d = pc_q + (next2_q ? PC_W'(3) : PC_W'(2));
         need = next2_q ? bsls_pkg::CYC_THREE : bsls_pkg::CYC_TWO;
      end
      if (ir_q.op >= bsls_pkg::OP_BRANCH_FLAG_SET &&
          ir_q.op <= bsls_pkg::OP_BRANCH_IRQ_DISABLED && cond) begin
         pc_d = pc_q + {{(PC_W-7){ir_q.imm[6]}}, ir_q.imm[6:0]} +
                PC_W'(1);
         need = bsls_pkg::CYC_TWO;
      end
   end

   // ==========================================================
   // Data-space request, held until the memory answers
   always_comb begin
      DM_REQ.valid = exec && is_mem && !mem_done_q;
      DM_REQ.we = mem_we;
      DM_REQ.addr = mem_addr;
      DM_REQ.wdata = rf_q[ir_q.rd];
   end

   // Finish once nominal cycles passed and memory answered
   assign done = exec && (cyc_q >= need) &&
                 (!is_mem || mem_done_q || (DM_REQ.valid && DM_READY));
   assign ld_data = mem_done_q ? ld_q : DM_RDATA;

   // Memory answer tracking and read data capture
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         mem_done_q <= 1'b0;
         ld_q <= 8'h00;
      end else if (start || done) begin
         mem_done_q <= 1'b0;
      end else if (DM_REQ.valid && DM_READY) begin
         mem_done_q <= 1'b1;
         ld_q <= DM_RDATA;
      end
   end

   // ==========================================================
   // Sequencer: idle, then execute until done
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= bsls_pkg::ST_IDLE;
         cyc_q <= 3'h0;
      end else begin
         case (state_q)
            bsls_pkg::ST_IDLE: begin
               if (start) begin
                  state_q <= bsls_pkg::ST_EXEC;
                  cyc_q <= bsls_pkg::CYC_ONE;
               end
            end
            bsls_pkg::ST_EXEC: begin
               if (done) begin
                  state_q <= bsls_pkg::ST_IDLE;
               end else if (cyc_q != 3'h7) begin
                  cyc_q <= cyc_q + 3'h1;
               end
            end
            default: state_q <= bsls_pkg::ST_IDLE;
         endcase
      end
   end

   // Last result: cycles used and whether a skip or branch was taken
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         last_cyc_q <= 3'h0;
         taken_q <= 1'b0;
      end else if (done) begin
         last_cyc_q <= cyc_q;
         taken_q <= cond;
      end
   end

   // Program counter: software while idle, execution at done
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pc_q <= '0;
      end else if (done) begin
         pc_q <= pc_d;
      end else if (!exec && wr_q && (wr_addr_q == bsls_pkg::OFS_PC)) begin
         pc_q <= HWDATA[PC_W-1:0];
      end
   end

   // ==========================================================
   // General registers: software while idle, loads and pointers at done
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < 32; i++) begin
            rf_q[i] <= bsls_pkg::GPR_RST;
         end
      end else if (done) begin
         if (ptr_wr) begin
            rf_q[ptr_lo] <= ptr_new[7:0];
            rf_q[ptr_lo + 5'h01] <= ptr_new[15:8];
         end
         if (rd_wr) begin
            rf_q[ir_q.rd] <= ld_data;
         end
      end else if (!exec && wr_q && wr_addr_q[7] &&
                   (wr_addr_q[1:0] == 2'h0)) begin
         rf_q[wr_addr_q[6:2]] <= HWDATA[7:0];
      end
   end

endmodule

// [tb/bsls_exec_asserts.sv]
// Port checker for the execution unit.
// Assumes it is bound to every bsls_exec instance.
module bsls_exec_asserts (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire bsls_pkg::bsls_dm_req_t DM_REQ,
   input wire logic DM_READY
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Bus and memory relations
   logic rd_ph;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   sequence s_wait;
      DM_REQ.valid && !DM_READY;
   endsequence
   sequence s_take;
      DM_REQ.valid && DM_READY;
   endsequence
   // Read address phase accepted
   assign rd_ph = HSEL && HREADY && HTRANS[1] && !HWRITE;
   a_ready_high: assert property (HREADYOUT)
      else $error("wait state inserted");
   a_resp_okay: assert property (!HRESP)
      else $error("error response");
   a_hold_valid: assert property (s_wait |=> DM_REQ.valid)
      else $error("request dropped early");
   a_hold_addr: assert property (
      s_wait |=> $stable(DM_REQ.addr) && $stable(DM_REQ.we))
      else $error("request address moved");
   a_hold_wdata: assert property (s_wait |=> $stable(DM_REQ.wdata))
      else $error("write data moved");
   a_drop_taken: assert property (s_take |=> !DM_REQ.valid)
      else $error("second access issued");
   a_unmapped_zero: assert property (
      rd_ph && HADDR[31:8] != 24'h0 |=> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_flags_upper: assert property (
      rd_ph && HADDR == 32'h10 |=> HRDATA[31:8] == 24'h0)
      else $error("flags upper bits set");
endmodule

bind bsls_exec bsls_exec_asserts chk_u (.CLK, .NRST, .HSEL, .HADDR,
   .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .DM_REQ,
   .DM_READY);

// [tb/bsls_dmem.sv]
// Data memory model of 256 bytes, prompt or two cycles late.
// Assumes the unit holds each request until ready.
module bsls_dmem (
   input wire logic CLK,
   input wire logic NRST,
   input wire bsls_pkg::bsls_dm_req_t req,
   input wire logic slow,
   output logic [7:0] rdata,
   output logic ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:255];
   logic [1:0] wait_q;
   // ==========
   // Answer, inverse data while not ready
   assign ready = req.valid && (!slow || wait_q == 2'h2);
   assign rdata = ready ? mem[req.addr[7:0]] : ~mem[req.addr[7:0]];
   // Wait counter
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) wait_q <= 2'h0;
      else if (!req.valid || ready) wait_q <= 2'h0;
      else wait_q <= wait_q + 2'h1;
   end
   // Store on accepted write
   always @(posedge CLK) begin
      if (ready && req.we) mem[req.addr[7:0]] <= req.wdata;
   end
endmodule

// [tb/branch_skip_load_store_exec_test.sv]
// Self-checking bench for bsls_exec with a data memory model.
// Assumes package, design, model and checker compile first.
module branch_skip_load_store_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Signals, shadow memory and tables
   logic clk, nrst, hwrite, hready, slow, dm_ready, ctl, t;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0] io_rdata, dm_rdata, flg, v, w, lo;
   logic [4:0] io_addr, ia;
   logic [2:0] sk, b;
   logic [16:0] im;
   logic [21:0] pc, ep, dl;
   logic [15:0] last_a, a, pv, ea, np;
   logic [7:0] sh [0:255];
   bsls_pkg::bsls_dm_req_t dm_req;
   int num_errors = 0;
   int comparisons = 0;
   int o, m, p, q, pr, rg;
   int ra [5] = '{8, 12, 16, 148, 256};
   int fi [6:25] = '{0,0,1,1,0,0,0,0,2,2,8,8,5,5,6,6,3,3,7,7};
   int cy [26:31] = '{3, 2, 2, 2, 1, 1};
   bsls_exec dut_u (.CLK(clk), .NRST(nrst), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
      .DM_REQ(dm_req), .DM_RDATA(dm_rdata), .DM_READY(dm_ready),
      .IO_ADDR(io_addr), .IO_RDATA(io_rdata));
   bsls_dmem mem_u (.CLK(clk), .NRST(nrst), .req(dm_req), .slow(slow),
      .rdata(dm_rdata), .ready(dm_ready));
   // Clock
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   // Address of each accepted memory access
   always @(posedge clk) begin
      if (dm_req.valid && dm_ready) last_a <= dm_req.addr;
   end
   // Watchdog
   initial begin
      #(40 * 40000);
      num_errors++;
      end_of_test();
   end
   // ==========
   // Tasks and expectation functions
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         $display("FAIL %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] ad, d);
      hwrite <= wr;
      haddr <= ad;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic gw(input int n, input logic [7:0] x);
      ahb(1, 32'h80 + 4 * n, {24'h0, x});
   endtask
   task automatic prep();
      flg = $urandom;
      pc = $urandom;
      ctl = $urandom;
      ahb(1, 16, {24'h0, flg});
      ahb(1, 12, {10'h0, pc});
      ahb(1, 4, {31'h0, ctl});
   endtask
   task automatic run(input logic [31:0] ins, input logic [21:0] epc,
                      input logic [2:0] ec, input logic et);
      int n;
      ahb(1, 0, ins);
      n = 0;
      do begin
         ahb(0, 8, 0);
         n++;
      end while (r[0] !== 1'b0 && n < 40);
      chk("busy", 0, r[0]);
      if (ec != 0) chk("cycles", ec, r[10:8]);
      if (ins[31:27] inside {[1:25]}) chk("taken", et, r[1]);
      ahb(0, 12, 0);
      chk("pc", epc, r[21:0]);
      ahb(0, 16, 0);
      chk("flags", flg, r);
   endtask
   function automatic logic br_t(int op, logic [8:0] f, logic [2:0] s);
      return f[op < 8 ? s : fi[op]] == (!op[0] ^ (op inside {12,13,16,17}));
   endfunction
   function automatic logic [15:0] eadr(int op, int md, logic [15:0] pp,
                                        logic [15:0] da, int dq);
      if (op == 26 || op == 29) return da;
      if (op == 28 || op == 31) return pp + dq[15:0];
      return md == 2 ? pp - 16'h1 : pp;
   endfunction
   // ==========
   // Main sequence
   initial begin
      nrst = 0;
      {htrans, hwrite, haddr, hwdata, io_rdata, slow} = '0;
      void'($urandom(39));
      for (int i = 0; i < 256; i++) begin
         sh[i] = 8'(i) ^ 8'hA5;
         mem_u.mem[i] = sh[i];
      end
      repeat (20) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      ahb(1, 32'h100, 32'hFFFF_FFFF);
      foreach (ra[j]) begin
         ahb(0, ra[j], 0);
         chk("reset", 0, r);
      end
      $display("test reset done");
      for (int i = 0; i < 80; i++) begin
         o = 6 + i % 20;
         prep();
         im = 17'($urandom);
         t = br_t(o, {flg[2] ^ flg[3], flg}, im[9:7]);
         ep = pc + 22'h1 + (t ? {{15{im[6]}}, im[6:0]} : 22'h0);
         run({o[4:0], 10'h0, im}, ep, t ? 3'h2 : 3'h1, t);
      end
      $display("test branches done");
      for (int i = 0; i < 48; i++) begin
         o = i % 6;
         prep();
         v = $urandom;
         w = i % 12 < 6 ? v : 8'($urandom);
         b = $urandom;
         ia = $urandom;
         io_rdata <= w;
         gw(3, v);
         gw(4, w);
         gw(30, v);
         gw(31, w);
         t = o == 1 ? v == w : (o < 4 ? v[b] : w[b]) == o[0];
         sk = ctl ? 3'h3 : 3'h2;
         ep = o == 0 ? {6'h0, w, v} : pc + (t ? 22'(sk) : 22'h1);
         run({o[4:0], 5'h3, o == 1 ? 5'h4 : 5'h3, 9'h0, ia, b}, ep,
             o == 0 ? 3'h3 : (t ? sk : 3'h1), t);
         if (o > 3) chk("io_addr", ia, io_addr);
      end
      $display("test skips done");
      for (int i = 0; i < 60; i++) begin
         o = 26 + $urandom % 6;
         m = $urandom % 3;
         p = $urandom % 4;
         q = $urandom % 64;
         a = $urandom;
         pv = $urandom;
         v = $urandom;
         rg = 1 + $urandom % 15;
         prep();
         slow <= 1'($urandom);
         pr = o == 28 || o == 31 ? (p < 2 ? 28 : 30) : 26 + 2 * (p > 2 ? 2 : p);
         gw(pr, pv[7:0]);
         gw(pr + 1, pv[15:8]);
         gw(rg, v);
         im = o == 26 || o == 29 ? {1'b0, a} : {p[1:0], m[1:0], 7'h0, q[5:0]};
         ea = eadr(o, m, pv, a, q);
         dl = o == 26 || o == 29 ? 22'h2 : 22'h1;
         run({o[4:0], rg[4:0], 5'h0, im}, pc + dl,
             slow ? 3'h3 : 3'(cy[o]), 0);
         chk("addr", ea, last_a);
         if (o < 29) begin
            ahb(0, 32'h80 + 4 * rg, 0);
            chk("load", sh[ea[7:0]], r);
         end else begin
            chk("store", v, mem_u.mem[ea[7:0]]);
            sh[ea[7:0]] = v;
         end
         np = (o == 27 || o == 30) && m != 0 ? (m == 1 ? pv + 16'h1 : pv - 16'h1) : pv;
         ahb(0, 32'h80 + 4 * pr, 0);
         lo = r[7:0];
         ahb(0, 32'h84 + 4 * pr, 0);
         chk("pointer", np, {r[7:0], lo});
      end
      $display("test memory done");
      // Start while busy is refused, sticky until written clear
      ahb(1, 0, 0);
      ahb(1, 0, 32'h4000_0000);
      ahb(0, 8, 0);
      chk("refused", 1, r[2]);
      ahb(0, 0, 0);
      chk("instr", 0, r);
      ahb(1, 8, 32'h4);
      ahb(0, 8, 0);
      chk("cleared", 0, r[2]);
      $display("test refusal done");
      end_of_test();
   end
endmodule
